// file: testbench.sv
// self-checking bench for the address and endpoint zero control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {logic [7:0] a, d, e;} uae_row_t;
    logic       sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, cpu_fifo_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, cpu_fifo_addr = 8'h00, cpu_fifo_data = 8'h00;
    logic       tok_valid, data_start, ack_start, xact_done, xact_acked, eng_byte_valid, eng_byte_ready;
    logic       tok_hit_q, tok_func_b_q, ram_we_q, cpu_stall, cfg_large_q, cfg_five_q;
    logic [1:0] tok_pid;
    logic [6:0] tok_addr;
    logic [3:0] tok_endp, xact_mode;
    logic [4:0] eng_byte_offset;
    logic [7:0] eng_byte_data, reg_rdata, ram_addr_q, ram_wdata_q;
    logic [2:0] tok_ep_q, tok_resp_q;
    int         mismatches = 0, total_checks = 0, cycles = 0;
    logic [7:0] offs [4] = '{8'h10, 8'h12, 8'h40, 8'h42};
    // register rows: offset, written, read back
    uae_row_t rows [7] = '{'{8'h1F, 8'hFF, 8'hC0}, '{8'h1F, 8'h00, 8'h00}, '{8'h33, 8'hFF, 8'h00},
        '{8'h10, 8'h85, 8'h85}, '{8'h40, 8'h86, 8'h86}, '{8'h12, 8'h01, 8'h01}, '{8'h42, 8'h03, 8'h03}};
    // token rows: {endpoint, pid}, address, {hit, func b, ep, answer}
    uae_row_t toks [4] = '{'{8'h00, 8'h05, 8'h81}, '{8'h01, 8'h06, 8'hEB}, '{8'h11, 8'h05, 8'h88},
        '{8'h02, 8'h05, 8'h82}};
    always #20 sys_clk = ~sys_clk;
    uae_usb_address_endpoint0_control u_dut (.*);
    uae_eng_model u_eng (.*);
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk("register", reg_rdata, e);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            end_sim;
        end
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        foreach (offs[i]) rd(offs[i], 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        foreach (toks[i]) begin
            u_eng.tok(toks[i].a[1:0], toks[i].d[6:0], toks[i].a[7:4]);
            #1 chk("route", {tok_hit_q, tok_func_b_q, tok_ep_q, tok_resp_q}, toks[i].e);
        end
        u_eng.tok(2'b10, 7'h07, 4'h0);
        #1 chk("foreign", {7'h00, tok_hit_q}, 8'h00);
        wr(8'h10, 8'h05);
        u_eng.tok(2'b00, 7'h05, 4'h0);
        #1 chk("disabled", {7'h00, tok_hit_q}, 8'h00);
        wr(8'h10, 8'h85);
        u_eng.tok(2'b00, 7'h05, 4'h0);
        u_eng.ev(3'b100, 1'b0, 4'h0);
        {cpu_fifo_wr, cpu_fifo_addr, cpu_fifo_data} <= {1'b1, 8'hF8, 8'h5A};
        @(posedge sys_clk);
        cpu_fifo_wr <= 1'b0;
        #1 chk("blocked", {7'h00, ram_we_q}, 8'h00);
        u_eng.rx(5'h02, 8'hAB);
        #1 chk("fifo", ram_addr_q, 8'hFA);
        chk("stall", {7'h00, cpu_stall}, 8'h01);
        repeat (3) @(posedge sys_clk);
        wr(8'h12, 8'h01);
        rd(8'h12, 8'h81);
        u_eng.ev(3'b010, 1'b0, 4'h0);
        u_eng.ev(3'b001, 1'b1, 4'h1);
        wr(8'h12, 8'h02);
        rd(8'h12, 8'h11);
        wr(8'h12, 8'h03);
        rd(8'h12, 8'h03);
        u_eng.tok(2'b01, 7'h05, 4'h0);
        u_eng.ev(3'b001, 1'b1, 4'h1);
        rd(8'h12, 8'h51);
        wr(8'h12, 8'h01);
        u_eng.tok(2'b10, 7'h05, 4'h0);
        u_eng.ev(3'b001, 1'b0, 4'h1);
        rd(8'h12, 8'h21);
        wr(8'h1F, 8'h40);
        u_eng.tok(2'b10, 7'h05, 4'h3);
        #1 chk("five", {tok_hit_q, tok_func_b_q, tok_ep_q, tok_resp_q}, 8'h9B);
        u_eng.ev(3'b001, 1'b0, 4'h2);
        wr(8'h42, 8'h83);
        rd(8'h42, 8'h83);
        end_sim;
    end
endmodule // testbench
`default_nettype wire

// file: uae_eng_model.sv
// engine side stand-in: tokens, transaction events and received bytes
`timescale 1ns/1ps
`default_nettype none
module uae_eng_model (
    // clock
    input  wire logic  sys_clk,
    // token
    output var logic       tok_valid,
    output var logic [1:0] tok_pid,
    output var logic [6:0] tok_addr,
    output var logic [3:0] tok_endp,
    // transaction events
    output var logic       data_start,
    output var logic       ack_start,
    output var logic       xact_done,
    output var logic       xact_acked,
    output var logic [3:0] xact_mode,
    // received byte, driven for one cycle without waiting for ready
    output var logic       eng_byte_valid,
    output var logic [4:0] eng_byte_offset,
    output var logic [7:0] eng_byte_data
);
    initial begin
        {tok_valid, tok_pid, tok_addr, tok_endp, data_start, ack_start} = '0;
        {xact_done, xact_acked, xact_mode, eng_byte_valid, eng_byte_offset, eng_byte_data} = '0;
    end
    task automatic tok(input logic [1:0] p, input logic [6:0] a, input logic [3:0] ep);
        {tok_valid, tok_pid, tok_addr, tok_endp} <= {1'b1, p, a, ep};
        @(posedge sys_clk);
        {tok_valid, tok_addr} <= {1'b0, ~a};
    endtask
    // trailing delay keeps two events apart in time
    task automatic ev(input logic [2:0] m, input logic k, input logic [3:0] md);
        {data_start, ack_start, xact_done, xact_acked, xact_mode} <= {m, k, md};
        @(posedge sys_clk);
        {data_start, ack_start, xact_done, xact_acked, xact_mode} <= {3'b000, ~k, ~md};
        #1;
    endtask
    task automatic rx(input logic [4:0] o, input logic [7:0] d);
        {eng_byte_valid, eng_byte_offset, eng_byte_data} <= {1'b1, o, d};
        @(posedge sys_clk);
        {eng_byte_valid, eng_byte_data} <= {1'b0, ~d};
    endtask
endmodule // uae_eng_model
`default_nettype wire

// file: uae_fifo_writer.sv
// user ram write port: engine fifo bytes with cpu stall, cpu writes otherwise
`timescale 1ns/1ps
`default_nettype none
module uae_fifo_writer (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // engine byte
    input  wire logic       eng_valid,
    input  wire logic [7:0] eng_addr,
    input  wire logic [7:0] eng_data,
    output logic            eng_ready,
    // cpu write, already filtered
    input  wire logic       cpu_we,
    input  wire logic [7:0] cpu_addr,
    input  wire logic [7:0] cpu_data,
    // ram port
    output logic            ram_we_q,
    output logic [7:0]      ram_addr_q,
    output logic [7:0]      ram_wdata_q,
    output logic            cpu_stall
);
    logic [1:0] stall_cnt_q;
    logic       take;

    assign eng_ready = (stall_cnt_q == 2'h0);
    assign take      = eng_valid && eng_ready;
    assign cpu_stall = (stall_cnt_q != 2'h0);

    // each accepted byte owns the data bus for three cycles
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stall_cnt_q <= 2'h0;
        end else if (take) begin
            stall_cnt_q <= uae_pkg::STALL_CYCLES_PER_BYTE;
        end else if (stall_cnt_q != 2'h0) begin
            stall_cnt_q <= stall_cnt_q - 2'h1;
        end
    end

    // engine owns the bus; a cpu write during a stall is dropped
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ram_we_q    <= 1'b0;
            ram_addr_q  <= 8'h00;
            ram_wdata_q <= 8'h00;
        end else if (take) begin
            ram_we_q    <= 1'b1;
            ram_addr_q  <= eng_addr;
            ram_wdata_q <= eng_data;
        end else if (cpu_we && !cpu_stall) begin
            ram_we_q    <= 1'b1;
            ram_addr_q  <= cpu_addr;
            ram_wdata_q <= cpu_data;
        end else begin
            ram_we_q    <= 1'b0;
        end
    end
endmodule // uae_fifo_writer
`default_nettype wire

// file: uae_pkg.sv
// constants, types and helper functions of the address and endpoint zero control block
`default_nettype none
package uae_pkg;
    // register offsets
    localparam logic [7:0] OFS_ADDR_A   = 8'h10;
    localparam logic [7:0] OFS_MODE_A0  = 8'h12;
    localparam logic [7:0] OFS_USB_CTRL = 8'h1F;
    localparam logic [7:0] OFS_ADDR_B   = 8'h40;
    localparam logic [7:0] OFS_MODE_B0  = 8'h42;
    localparam logic [7:0] REG_RESET    = 8'h00;

    // field positions
    localparam int ADDR_EN_BIT    = 7;
    localparam int CTRL_SIZE_BIT  = 7;
    localparam int CTRL_FIVE_BIT  = 6;
    localparam int MODE_SETUP_BIT = 7;
    localparam int MODE_IN_BIT    = 6;
    localparam int MODE_OUT_BIT   = 5;
    localparam int MODE_ACK_BIT   = 4;

    // cpu stall per byte written by the engine
    localparam logic [1:0] STALL_CYCLES_PER_BYTE = 2'h3;
    localparam logic [5:0] FIFO_LEN_SMALL        = 6'h08;
    localparam logic [5:0] FIFO_LEN_LARGE        = 6'h20;

    // mode codes
    localparam logic [3:0] MODE_DISABLE    = 4'h0;
    localparam logic [3:0] MODE_NAK_IN_OUT = 4'h1;
    localparam logic [3:0] MODE_STATUS_OUT = 4'h2;
    localparam logic [3:0] MODE_STALL_IO   = 4'h3;
    localparam logic [3:0] MODE_IGNORE_IO  = 4'h4;
    localparam logic [3:0] MODE_ISO_OUT    = 4'h5;
    localparam logic [3:0] MODE_STATUS_IN  = 4'h6;
    localparam logic [3:0] MODE_ISO_IN     = 4'h7;

    typedef enum logic [1:0] {
        PID_SETUP = 2'b00,
        PID_IN    = 2'b01,
        PID_OUT   = 2'b10,
        PID_NONE  = 2'b11
    } uae_pid_t;

    typedef enum logic [2:0] {
        EP_A0 = 3'b000,
        EP_A1 = 3'b001,
        EP_A2 = 3'b010,
        EP_A3 = 3'b011,
        EP_A4 = 3'b100,
        EP_B0 = 3'b101,
        EP_B1 = 3'b110
    } uae_ep_t;

    typedef enum logic [2:0] {
        RESP_IGNORE   = 3'b000,
        RESP_ACCEPT   = 3'b001,
        RESP_NAK      = 3'b010,
        RESP_STALL    = 3'b011,
        RESP_CHECK    = 3'b100,
        RESP_TX_ZERO  = 3'b101,
        RESP_TX_COUNT = 3'b110,
        RESP_ALWAYS   = 3'b111
    } uae_resp_t;

    // fifo start address in user ram for each configuration
    function automatic logic [7:0] fifo_base(input logic [2:0] ep, input logic size, input logic five);
        logic [7:0] b;
        b = 8'hF8;
        case ({size, five, ep})
            {2'b00, EP_B1}, {2'b01, EP_A4}: b = 8'hD8;
            {2'b00, EP_B0}, {2'b01, EP_A3}: b = 8'hE0;
            {2'b00, EP_A2}, {2'b01, EP_A2}: b = 8'hE8;
            {2'b00, EP_A1}, {2'b01, EP_A1}: b = 8'hF0;
            {2'b00, EP_A0}, {2'b01, EP_A0}: b = 8'hF8;
            {2'b10, EP_B0}, {2'b11, EP_A3}: b = 8'hA8;
            {2'b10, EP_B1}, {2'b11, EP_A4}: b = 8'hB0;
            {2'b10, EP_A0}, {2'b11, EP_A0}: b = 8'hB8;
            {2'b10, EP_A1}, {2'b11, EP_A1}: b = 8'hC0;
            {2'b10, EP_A2}, {2'b11, EP_A2}: b = 8'hE0;
            default: b = 8'hF8;
        endcase
        return b;
    endfunction

    function automatic logic [5:0] fifo_len(input logic [2:0] ep, input logic size);
        return (size && (ep == EP_A1 || ep == EP_A2)) ? FIFO_LEN_LARGE : FIFO_LEN_SMALL;
    endfunction

    // handshake decision for one token kind under a mode code
    function automatic uae_resp_t mode_response(input logic [3:0] mode, input logic [1:0] pid);
        uae_resp_t r;
        r = RESP_IGNORE;
        case (mode)
            MODE_DISABLE:    r = RESP_IGNORE;
            MODE_NAK_IN_OUT: r = (pid == PID_SETUP) ? RESP_ACCEPT : RESP_NAK;
            MODE_STATUS_OUT: r = (pid == PID_SETUP) ? RESP_ACCEPT : (pid == PID_IN) ? RESP_STALL : RESP_CHECK;
            MODE_STALL_IO:   r = (pid == PID_SETUP) ? RESP_ACCEPT : RESP_STALL;
            MODE_IGNORE_IO:  r = (pid == PID_SETUP) ? RESP_ACCEPT : RESP_IGNORE;
            MODE_ISO_OUT:    r = (pid == PID_OUT) ? RESP_ALWAYS : RESP_IGNORE;
            MODE_STATUS_IN:  r = (pid == PID_SETUP) ? RESP_ACCEPT : (pid == PID_IN) ? RESP_TX_ZERO : RESP_STALL;
            MODE_ISO_IN:     r = (pid == PID_IN) ? RESP_TX_COUNT : RESP_IGNORE;
            default:         r = RESP_IGNORE;
        endcase
        return r;
    endfunction
endpackage
`default_nettype wire

// file: uae_usb_address_endpoint0_control.sv
// device addresses, endpoint configuration, endpoint zero mode registers and fifo placement
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - two address registers at 0x10 and 0x40
// - reset clears addresses and their enables
// - respond only when address enable bit set
// - control bit 7 sizes, bit 6 address count
// - default: A three endpoints, B two
// - fifo start and size follow configuration
// - fifos live in user data ram
// - engine fifo byte stalls cpu three cycles
// - endpoint zero bidirectional, others one direction
// - mode registers cleared by reset
// - five endpoint mode: 0x42 is endpoint three
// - ack flag set on acked transaction
// - out received flag set on out token
// - in received flag set on in token
// - setup flag set by engine, cpu write clears
// - setup flag forced high from data to ack
// - engine update locks bits until cpu read
// - lock only on endpoint zero mode registers
// - setup flag blocks cpu endpoint zero fifo writes
// - status out ack out only; setup may overwrite
// - mode codes decode to setup, in, out handshakes
module uae_usb_address_endpoint0_control (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // token from the serial interface engine
    input  wire logic       tok_valid,
    input  wire logic [1:0] tok_pid,
    input  wire logic [6:0] tok_addr,
    input  wire logic [3:0] tok_endp,
    // routing answer, one cycle after the token
    output logic            tok_hit_q,
    output logic            tok_func_b_q,
    output logic [2:0]      tok_ep_q,
    output logic [2:0]      tok_resp_q,
    // transaction events for the current endpoint
    input  wire logic       data_start,
    input  wire logic       ack_start,
    input  wire logic       xact_done,
    input  wire logic       xact_acked,
    input  wire logic [3:0] xact_mode,
    // received data byte from the engine
    input  wire logic       eng_byte_valid,
    input  wire logic [4:0] eng_byte_offset,
    input  wire logic [7:0] eng_byte_data,
    output logic            eng_byte_ready,
    // cpu fifo write
    input  wire logic       cpu_fifo_wr,
    input  wire logic [7:0] cpu_fifo_addr,
    input  wire logic [7:0] cpu_fifo_data,
    // user ram port and cpu hold
    output logic            ram_we_q,
    output logic [7:0]      ram_addr_q,
    output logic [7:0]      ram_wdata_q,
    output logic            cpu_stall,
    // configuration seen by the engine
    output logic            cfg_large_q,
    output logic            cfg_five_q
);
    logic [7:0] addr_a_q;
    logic [7:0] addr_b_q;
    logic [6:0] mode_q [2];
    logic [1:0] setup_q;
    logic [1:0] lock_q;
    logic [1:0] hold_q;
    logic [7:0] reg_rdata_q;
    logic [2:0] cur_ep_q;
    logic [1:0] cur_pid_q;
    logic       cur_valid_q;

    logic       hit_a;
    logic       hit_b;
    logic       hit_d;
    logic       func_b_d;
    logic [2:0] ep_d;
    logic [2:0] resp_d;
    logic [1:0] mode_wr;
    logic [1:0] mode_rd;
    logic [1:0] ctl_fmt;
    logic [1:0] upd;
    logic [1:0] setup_set;
    logic [1:0] setup_end;
    logic [2:0] reg_ep [2];
    logic [7:0] fifo_lo;
    logic [5:0] fifo_sz;
    logic [7:0] eng_ram_addr;
    logic       cpu_fifo_ok;

    // configuration register: only the two endpoint layout bits are kept
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cfg_large_q <= 1'b0;
            cfg_five_q  <= 1'b0;
        end else if (reg_wr && reg_addr == uae_pkg::OFS_USB_CTRL) begin
            cfg_large_q <= reg_wdata[uae_pkg::CTRL_SIZE_BIT];
            cfg_five_q  <= reg_wdata[uae_pkg::CTRL_FIVE_BIT];
        end
    end

    // address registers, fully writable at any time
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            addr_a_q <= uae_pkg::REG_RESET;
            addr_b_q <= uae_pkg::REG_RESET;
        end else if (reg_wr) begin
            if (reg_addr == uae_pkg::OFS_ADDR_A) begin
                addr_a_q <= reg_wdata;
            end
            if (reg_addr == uae_pkg::OFS_ADDR_B) begin
                addr_b_q <= reg_wdata;
            end
        end
    end

    // token routing
    always_comb begin
        hit_a    = addr_a_q[uae_pkg::ADDR_EN_BIT] && (tok_addr == addr_a_q[6:0]);
        hit_b    = !cfg_five_q && addr_b_q[uae_pkg::ADDR_EN_BIT] && (tok_addr == addr_b_q[6:0]);
        hit_d    = 1'b0;
        func_b_d = 1'b0;
        ep_d     = uae_pkg::EP_A0;
        if (hit_a) begin
            // a shared address on both registers is served by function A
            if (cfg_five_q && tok_endp <= 4'h4) begin
                hit_d = 1'b1;
                ep_d  = tok_endp[2:0];
            end else if (!cfg_five_q && tok_endp <= 4'h2) begin
                hit_d = 1'b1;
                ep_d  = tok_endp[2:0];
            end
        end else if (hit_b && tok_endp <= 4'h1) begin
            hit_d    = 1'b1;
            func_b_d = 1'b1;
            ep_d     = (tok_endp == 4'h0) ? uae_pkg::EP_B0 : uae_pkg::EP_B1;
        end
    end

    // handshake from the mode register that owns the endpoint
    always_comb begin
        resp_d = uae_pkg::RESP_IGNORE;
        if (ep_d == uae_pkg::EP_A0) begin
            resp_d = uae_pkg::mode_response(mode_q[0][3:0], tok_pid);
        end else if (ep_d == uae_pkg::EP_B0 || (cfg_five_q && ep_d == uae_pkg::EP_A3)) begin
            resp_d = uae_pkg::mode_response(mode_q[1][3:0], tok_pid);
        end
        // setup is only meaningful on the bidirectional control endpoints
        if (tok_pid == uae_pkg::PID_SETUP && ep_d != uae_pkg::EP_A0 && ep_d != uae_pkg::EP_B0) begin
            resp_d = uae_pkg::RESP_IGNORE;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tok_hit_q    <= 1'b0;
            tok_func_b_q <= 1'b0;
            tok_ep_q     <= uae_pkg::EP_A0;
            tok_resp_q   <= uae_pkg::RESP_IGNORE;
        end else begin
            tok_hit_q    <= tok_valid && hit_d;
            if (tok_valid) begin
                tok_func_b_q <= func_b_d;
                tok_ep_q     <= ep_d;
                tok_resp_q   <= hit_d ? resp_d : uae_pkg::RESP_IGNORE;
            end
        end
    end

    // current transaction context, held until the next token
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cur_valid_q <= 1'b0;
            cur_ep_q    <= uae_pkg::EP_A0;
            cur_pid_q   <= uae_pkg::PID_NONE;
        end else if (tok_valid) begin
            cur_valid_q <= hit_d;
            cur_ep_q    <= ep_d;
            cur_pid_q   <= tok_pid;
        end
    end

    // per mode register decode; index 1 changes meaning in five endpoint mode
    always_comb begin
        reg_ep[0] = uae_pkg::EP_A0;
        reg_ep[1] = cfg_five_q ? uae_pkg::EP_A3 : uae_pkg::EP_B0;
        ctl_fmt   = {!cfg_five_q, 1'b1};
        mode_wr   = {reg_wr && reg_addr == uae_pkg::OFS_MODE_B0, reg_wr && reg_addr == uae_pkg::OFS_MODE_A0};
        mode_rd   = {reg_rd && reg_addr == uae_pkg::OFS_MODE_B0, reg_rd && reg_addr == uae_pkg::OFS_MODE_A0};
        for (int i = 0; i < 2; i++) begin
            upd[i]       = xact_done && cur_valid_q && (cur_ep_q == reg_ep[i]);
            setup_set[i] = data_start && cur_valid_q && ctl_fmt[i] && (cur_ep_q == reg_ep[i])
                           && (cur_pid_q == uae_pkg::PID_SETUP);
            setup_end[i] = ack_start && cur_valid_q && (cur_ep_q == reg_ep[i]);
        end
    end

    // setup hold window: from setup data packet to the engine's ack
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hold_q <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (setup_set[i]) begin
                    hold_q[i] <= 1'b1;
                end else if (setup_end[i] || !ctl_fmt[i]) begin
                    hold_q[i] <= 1'b0;
                end
            end
        end
    end

    // lock after an engine update; a read in the update cycle does not unlock
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            lock_q <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!ctl_fmt[i]) begin
                    lock_q[i] <= 1'b0;
                end else if (upd[i]) begin
                    lock_q[i] <= 1'b1;
                end else if (mode_rd[i]) begin
                    lock_q[i] <= 1'b0;
                end
            end
        end
    end

    // setup received flag, or stall bit in non control format
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            setup_q <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!ctl_fmt[i]) begin
                    if (mode_wr[i]) begin
                        setup_q[i] <= reg_wdata[uae_pkg::MODE_SETUP_BIT];
                    end
                end else if (setup_set[i] || hold_q[i]) begin
                    setup_q[i] <= 1'b1;
                end else if (mode_wr[i]) begin
                    // any write clears, whatever the value
                    setup_q[i] <= 1'b0;
                end
            end
        end
    end

    // token flags, ack and mode bits
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mode_q[0][6:0] <= 7'h00;
            mode_q[1][6:0] <= 7'h00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (upd[i]) begin
                    // engine wins over a cpu write in the same cycle
                    if (ctl_fmt[i]) begin
                        if (cur_pid_q == uae_pkg::PID_IN) begin
                            mode_q[i][uae_pkg::MODE_IN_BIT] <= 1'b1;
                        end
                        if (cur_pid_q == uae_pkg::PID_OUT) begin
                            mode_q[i][uae_pkg::MODE_OUT_BIT] <= 1'b1;
                        end
                    end
                    if (xact_acked) begin
                        mode_q[i][uae_pkg::MODE_ACK_BIT] <= 1'b1;
                    end
                    mode_q[i][3:0] <= xact_mode;
                end else if (mode_wr[i] && !(ctl_fmt[i] && lock_q[i])) begin
                    mode_q[i][6:5] <= ctl_fmt[i] ? reg_wdata[6:5] : 2'b00;
                    mode_q[i][4:0] <= reg_wdata[4:0];
                end
            end
        end
    end

    // register read data, valid the cycle after the strobe
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                uae_pkg::OFS_ADDR_A:   reg_rdata_q <= addr_a_q;
                uae_pkg::OFS_ADDR_B:   reg_rdata_q <= addr_b_q;
                uae_pkg::OFS_MODE_A0:  reg_rdata_q <= {setup_q[0], mode_q[0]};
                uae_pkg::OFS_MODE_B0:  reg_rdata_q <= {setup_q[1], mode_q[1]};
                uae_pkg::OFS_USB_CTRL: reg_rdata_q <= {cfg_large_q, cfg_five_q, 6'h00};
                default:               reg_rdata_q <= 8'h00;
            endcase
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = reg_rdata_q;

    // engine byte placed inside the fifo of the current endpoint
    always_comb begin
        fifo_lo      = uae_pkg::fifo_base(cur_ep_q, cfg_large_q, cfg_five_q);
        fifo_sz      = uae_pkg::fifo_len(cur_ep_q, cfg_large_q);
        // offsets wrap inside the fifo so a long packet never spills into a neighbour
        eng_ram_addr = fifo_lo + {3'b000, eng_byte_offset & 5'(fifo_sz - 6'h01)};
    end

    // cpu writes into a control fifo are refused while its setup flag stands
    always_comb begin
        cpu_fifo_ok = 1'b1;
        for (int i = 0; i < 2; i++) begin
            if (ctl_fmt[i] && setup_q[i]) begin
                // modular distance: the fifo at 0xF8 would wrap a plain upper bound to zero
                if (8'(cpu_fifo_addr - uae_pkg::fifo_base(reg_ep[i], cfg_large_q, cfg_five_q))
                    < {2'b00, uae_pkg::FIFO_LEN_SMALL}) begin
                    cpu_fifo_ok = 1'b0;
                end
            end
        end
    end

    // no nak-in hold after a status stage, so setup data simply lands in the fifo
    uae_fifo_writer u_fifo_writer (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .eng_valid   (eng_byte_valid && cur_valid_q),
        .eng_addr    (eng_ram_addr),
        .eng_data    (eng_byte_data),
        .eng_ready   (eng_byte_ready),
        .cpu_we      (cpu_fifo_wr && cpu_fifo_ok),
        .cpu_addr    (cpu_fifo_addr),
        .cpu_data    (cpu_fifo_data),
        .ram_we_q    (ram_we_q),
        .ram_addr_q  (ram_addr_q),
        .ram_wdata_q (ram_wdata_q),
        .cpu_stall   (cpu_stall)
    );
endmodule // uae_usb_address_endpoint0_control
`default_nettype wire

// file: uae_usb_properties.sv
// port assertions of the address and endpoint zero control block
`timescale 1ns/1ps
`default_nettype none
module uae_props (
    // clock, reset, register port
    input wire logic       sys_clk,
    input wire logic       reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // token routing
    input wire logic       tok_valid,
    input wire logic       tok_hit_q,
    input wire logic [2:0] tok_ep_q,
    input wire logic [2:0] tok_resp_q,
    // fifo and configuration
    input wire logic       eng_byte_valid,
    input wire logic       eng_byte_ready,
    input wire logic       ram_we_q,
    input wire logic       cpu_stall,
    input wire logic       cfg_large_q,
    input wire logic       cfg_five_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    AST_STALL_LEN: assert property ($rose(cpu_stall) |-> cpu_stall [*3] ##1 !cpu_stall)
        else $error("stall not three cycles");
    AST_READY: assert property (eng_byte_ready == !cpu_stall)
        else $error("ready during stall");
    AST_STALL_WRITE: assert property ($rose(cpu_stall) |-> ram_we_q && $past(eng_byte_valid))
        else $error("stall without ram write");
    AST_HIT_CAUSE: assert property (tok_hit_q |-> $past(tok_valid))
        else $error("hit without token");
    AST_CFG: assert property (reg_wr && reg_addr == uae_pkg::OFS_USB_CTRL |=>
        {cfg_large_q, cfg_five_q} == $past(reg_wdata[7:6])) else $error("config bits wrong");
    AST_EP_SET: assert property (tok_hit_q && !cfg_five_q |-> tok_ep_q inside {0, 1, 2, 5, 6})
        else $error("endpoint outside two address set");
    AST_NONCTRL: assert property (tok_hit_q && tok_ep_q inside {1, 2, 6} |-> tok_resp_q == 3'h0)
        else $error("answer on plain endpoint");
    AST_FIVE_B: assert property (tok_hit_q && cfg_five_q |-> tok_ep_q <= 3'h4)
        else $error("second address used in five mode");
    cover property (tok_hit_q);
    cover property ($rose(cpu_stall));
    cover property (tok_hit_q && cfg_five_q);
endmodule // uae_props
bind uae_usb_address_endpoint0_control uae_props u_props (.*);
`default_nettype wire
